// [design/cpu_pipe_regs.svh]
`ifndef CPU_PIPE_REGS_SVH
`define CPU_PIPE_REGS_SVH

// Prefetch buffer: 96 bits as six halfwords
`define PF_BUF_HALFWORDS 3'h6
// One double word from program memory holds four halfwords
`define PF_DWORD_HALFWORDS 3'h4
// Highest fill level that still leaves room for a whole double word
`define PF_ROOM_LEVEL 3'h2
// Byte step between double-word fetch addresses
`define PF_ADDR_STEP 24'h000008
// Fetch address after reset
`define PF_RESET_ADDR 24'h000000
// Instruction field giving extra execute cycles
`define INSTR_EXTRA_LSB 0
`define INSTR_EXTRA_W 2
// Fewest cycles for a lone instruction to complete
`define PIPE_MIN_LATENCY 5

`endif

// [design/cpu_pipe_pkg.sv]
package cpu_pipe_pkg;

  typedef enum logic [1:0] {
    PF_IDLE = 2'b00,
    PF_WAIT = 2'b01,
    PF_DROP = 2'b10
  } pf_state_t;

  typedef logic [15:0] halfword_t;

endpackage : cpu_pipe_pkg

// [design/instruction_fetch_unit.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cpu_pipe_regs.svh"

module instruction_fetch_unit (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  // Redirect
  input  wire logic                 i_flush,
  input  wire logic [23:0]          i_target,
  // Program memory unit
  output logic                      o_pm_req,
  output logic [23:0]               o_pm_addr,
  input  wire logic                 i_pm_valid,
  input  wire logic [63:0]          i_pm_data,
  // Halfword stream to the queue
  output logic                      o_hw_valid,
  output cpu_pipe_pkg::halfword_t   o_hw_data,
  input  wire logic                 i_hw_take
);

  cpu_pipe_pkg::pf_state_t  state;
  cpu_pipe_pkg::pf_state_t  next_state;
  cpu_pipe_pkg::halfword_t  buffer [0:5];
  cpu_pipe_pkg::halfword_t  next_buffer [0:5];
  logic [2:0]               count;
  logic [2:0]               next_count;
  logic [1:0]               skip;
  logic                     load;
  logic                     issue;
  logic                     bypass;
  logic [63:0]              aligned;

  // An empty buffer forwards the arriving word's first halfword, so supply keeps pace
  assign o_hw_valid = (count != 3'h0) || load;
  assign o_hw_data  = (count != 3'h0) ? buffer[0] : aligned[15:0];
  assign load       = (state == cpu_pipe_pkg::PF_WAIT) && i_pm_valid && !i_flush;
  assign bypass     = load && (count == 3'h0) && i_hw_take;
  assign issue      = (state == cpu_pipe_pkg::PF_IDLE) && !o_pm_req && !i_flush
                      && (count <= `PF_ROOM_LEVEL);
  assign aligned    = i_pm_data >> {skip, 4'h0};

  always_comb begin
    next_count = count;
    for (int k = 0; k < 6; k++) begin
      next_buffer[k] = buffer[k];
    end
    if (i_hw_take && (count != 3'h0)) begin
      for (int k = 0; k < 5; k++) begin
        next_buffer[k] = buffer[k+1];
      end
      next_count = count - 3'h1;
    end
    if (load) begin
      for (int k = 0; k < 4; k++) begin
        if ((k < (4 - int'(skip))) && !(bypass && (k == 0))) begin
          next_buffer[next_count + 3'(k) - {2'h0, bypass}] = aligned[16*k +: 16];
        end
      end
      next_count = next_count + `PF_DWORD_HALFWORDS - {1'b0, skip} - {2'h0, bypass};
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      cpu_pipe_pkg::PF_IDLE: begin
        if (issue) begin
          next_state = cpu_pipe_pkg::PF_WAIT;
        end
      end
      cpu_pipe_pkg::PF_WAIT: begin
        if (i_flush) begin
          next_state = i_pm_valid ? cpu_pipe_pkg::PF_IDLE : cpu_pipe_pkg::PF_DROP;
        end else if (i_pm_valid) begin
          next_state = cpu_pipe_pkg::PF_IDLE;
        end
      end
      cpu_pipe_pkg::PF_DROP: begin
        if (i_pm_valid) begin
          next_state = cpu_pipe_pkg::PF_IDLE;
        end
      end
      default: next_state = cpu_pipe_pkg::PF_IDLE;
    endcase
  end

  // Buffer contents and fill level
  always_ff @(posedge i_clk) begin
    if (i_reset || i_flush) begin
      count <= 3'h0;
    end else begin
      count <= next_count;
      for (int k = 0; k < 6; k++) begin
        buffer[k] <= next_buffer[k];
      end
    end
  end

  // Request state and fetch address
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state     <= cpu_pipe_pkg::PF_IDLE;
      o_pm_req  <= 1'b0;
      o_pm_addr <= `PF_RESET_ADDR;
      skip      <= 2'h0;
    end else begin
      state    <= next_state;
      o_pm_req <= issue;
      if (i_flush) begin
        o_pm_addr <= {i_target[23:3], 3'h0};
        skip      <= i_target[2:1];
      end else if (load) begin
        o_pm_addr <= o_pm_addr + `PF_ADDR_STEP;
        skip      <= 2'h0;
      end
    end
  end

  a_no_req_full : assert property (@(posedge i_clk) disable iff (i_reset)
    (count > `PF_ROOM_LEVEL) |=> !o_pm_req)
    else $error("fetch request while prefetch buffer lacks room");

  a_addr_hold : assert property (@(posedge i_clk) disable iff (i_reset)
    (!load && !i_flush) |=> $stable(o_pm_addr))
    else $error("fetch address moved during stall");

  a_addr_step : assert property (@(posedge i_clk) disable iff (i_reset)
    (load && !i_flush) |=> (o_pm_addr == $past(o_pm_addr) + `PF_ADDR_STEP))
    else $error("fetch address did not step one double word");

  a_fill_bound : assert property (@(posedge i_clk) disable iff (i_reset)
    count <= `PF_BUF_HALFWORDS)
    else $error("prefetch buffer overfilled");

endmodule : instruction_fetch_unit
`default_nettype wire

// [design/cpu_pipeline_flow_control.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cpu_pipe_regs.svh"
// Function
// - Every stage takes at least one cycle
// - Up to five instructions, six with write back
// - One instruction completes per cycle once filled
// - Multicycle instruction holds execute full count
// - Prefetch fills queue independent of stages
// - Stop fetching when queue and buffer full
// - Hold address until double word fits
// - Mispredict flushes stages, queue, restarts fetch

module cpu_pipeline_flow_control #(
  parameter int QUEUE_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_RESET,
  // Program memory unit
  output logic                      O_PM_REQ,
  output logic [23:0]               O_PM_ADDR,
  input  wire logic                 I_PM_VALID,
  input  wire logic [63:0]          I_PM_DATA,
  // Flow redirect
  input  wire logic                 I_MISPREDICT,
  input  wire logic [23:0]          I_TARGET_ADDR,
  // Completion and status
  output logic                      O_WB_VALID,
  output cpu_pipe_pkg::halfword_t   O_WB_INSTR,
  output logic                      O_EXEC_HOLD,
  output logic [2:0]                O_OCCUPANCY
);

  localparam int QW = $clog2(QUEUE_DEPTH);

  cpu_pipe_pkg::halfword_t          queue [0:QUEUE_DEPTH-1];
  logic [QW-1:0]                    rd_ptr;
  logic [QW-1:0]                    wr_ptr;
  logic [QW:0]                      q_count;
  logic                             q_full;
  logic                             q_push;
  logic                             q_pop;
  logic                             hw_valid;
  cpu_pipe_pkg::halfword_t          hw_data;
  logic [4:0]                       stage_valid;
  cpu_pipe_pkg::halfword_t          stage_instr [0:4];
  logic [`INSTR_EXTRA_W-1:0]        exec_left;
  logic                             hold;
  logic [2:0]                       occupancy;

  // Stage 0 fetch, 1 decode, 2 address, 3 memory, 4 execute; write back is the output flop
  assign hold   = stage_valid[4] && (exec_left != '0);
  assign q_full = (q_count == (QW+1)'(QUEUE_DEPTH));
  assign q_push = hw_valid && !q_full && !I_MISPREDICT;
  assign q_pop  = (q_count != '0) && !hold && !I_MISPREDICT;

  function automatic logic [2:0] count_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < 6; k++) begin
      n = n + {2'h0, v[k]};
    end
    return n;
  endfunction : count_ones

  assign occupancy = count_ones({O_WB_VALID, stage_valid});

  instruction_fetch_unit u_fetch (
    .i_clk      (I_SYS_CLK),
    .i_reset    (I_RESET),
    .i_flush    (I_MISPREDICT),
    .i_target   (I_TARGET_ADDR),
    .o_pm_req   (O_PM_REQ),
    .o_pm_addr  (O_PM_ADDR),
    .i_pm_valid (I_PM_VALID),
    .i_pm_data  (I_PM_DATA),
    .o_hw_valid (hw_valid),
    .o_hw_data  (hw_data),
    .i_hw_take  (q_push)
  );

  // Instruction queue
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET || I_MISPREDICT) begin
      rd_ptr  <= '0;
      wr_ptr  <= '0;
      q_count <= '0;
    end else begin
      if (q_push) begin
        queue[wr_ptr] <= hw_data;
        wr_ptr        <= wr_ptr + 1'b1;
      end
      if (q_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      q_count <= q_count + (QW+1)'(q_push) - (QW+1)'(q_pop);
    end
  end

  // Processing stages
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET || I_MISPREDICT) begin
      stage_valid <= 5'h00;
    end else if (!hold) begin
      stage_valid <= {stage_valid[3:0], q_pop};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!hold) begin
      stage_instr[0] <= queue[rd_ptr];
      for (int k = 1; k < 5; k++) begin
        stage_instr[k] <= stage_instr[k-1];
      end
    end
  end

  // Execute cycle counter
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET || I_MISPREDICT) begin
      exec_left <= '0;
    end else if (hold) begin
      exec_left <= exec_left - 1'b1;
    end else if (stage_valid[3]) begin
      exec_left <= stage_instr[3][`INSTR_EXTRA_LSB +: `INSTR_EXTRA_W];
    end else begin
      exec_left <= '0;
    end
  end

  // Write back and status outputs
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET || I_MISPREDICT) begin
      O_WB_VALID  <= 1'b0;
      O_WB_INSTR  <= 16'h0000;
      O_EXEC_HOLD <= 1'b0;
      O_OCCUPANCY <= 3'h0;
    end else begin
      O_WB_VALID  <= stage_valid[4] && !hold;
      O_WB_INSTR  <= stage_instr[4];
      O_EXEC_HOLD <= hold;
      O_OCCUPANCY <= occupancy;
    end
  end

  sequence s_enter;
    (q_pop && (stage_valid == 5'h00)) ##0 !I_MISPREDICT;
  endsequence

  sequence s_hold_two;
    hold ##1 (!hold && !O_WB_VALID && O_EXEC_HOLD);
  endsequence

  a_min_latency : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET || I_MISPREDICT)
    s_enter |-> ##1 !stage_valid[4] [*4])
    else $error("instruction reached execute too early");

  a_occupancy : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    O_OCCUPANCY <= 3'h6)
    else $error("more than six instructions in flight");

  a_throughput : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET || I_MISPREDICT)
    (stage_valid[4] && !hold) |=> O_WB_VALID)
    else $error("executed instruction did not complete next cycle");

  a_exec_hold : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET || I_MISPREDICT)
    (!hold && stage_valid[3] && (stage_instr[3][`INSTR_EXTRA_LSB +: `INSTR_EXTRA_W] == 2'h1)) |=> s_hold_two)
    else $error("two-cycle instruction not held exactly one extra cycle");

  a_queue_fill : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET || I_MISPREDICT)
    (hw_valid && !q_full && !q_pop) |=> (q_count == $past(q_count) + 1'b1))
    else $error("queue not filled while buffer had data");

  a_flush : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    I_MISPREDICT |=> (stage_valid == 5'h00) && (q_count == '0) && !O_WB_VALID)
    else $error("pipeline not cleared on mispredict");

  a_upstream_hold : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET || I_MISPREDICT)
    hold |=> $stable(stage_valid) && $stable(stage_instr[3]))
    else $error("upstream stage moved during execute hold");

endmodule : cpu_pipeline_flow_control
`default_nettype wire

// [bench/program_memory_model.sv]
`timescale 1ns/10ps
`default_nettype none

module program_memory_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Fetch side
  input  wire logic        i_req,
  input  wire logic [23:0] i_addr,
  output var  logic        o_valid,
  output var  logic [63:0] o_data,
  // Behaviour control
  input  wire logic [3:0]  i_wait,
  input  wire logic [23:0] i_multi_addr
);
  logic        pend;
  logic [3:0]  cnt;
  logic [23:0] addr;
  logic [63:0] word;

  function automatic logic [63:0] dword(input logic [23:0] a);
    logic [23:0] h;
    for (int k = 0; k < 4; k++) begin
      h = a + 24'(2 * k);
      dword[16*k +: 16] = {h[14:1], (h == i_multi_addr) ? 2'h1 : 2'h0};
    end
  endfunction : dword

  // Released data bus shows the inverse of the last word
  assign o_data = o_valid ? word : ~word;

  // One request at a time, answered after i_wait idle cycles
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pend    <= 1'b0;
      o_valid <= 1'b0;
      word    <= 64'h0;
      cnt     <= 4'h0;
      addr    <= 24'h0;
    end else begin
      o_valid <= 1'b0;
      if (i_req && i_wait == 4'h0) begin
        o_valid <= 1'b1;
        word    <= dword(i_addr);
      end else if (i_req) begin
        pend <= 1'b1;
        cnt  <= i_wait - 4'h1;
        addr <= i_addr;
      end else if (pend && cnt == 4'h0) begin
        o_valid <= 1'b1;
        word    <= dword(addr);
        pend    <= 1'b0;
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : program_memory_model

`default_nettype wire

// [bench/test_cpu_pipeline_flow_control.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cpu_pipe_regs.svh"

module test_cpu_pipeline_flow_control;
  logic                    I_SYS_CLK = 1'b0;
  logic                    I_RESET = 1'b1;
  logic                    O_PM_REQ;
  logic [23:0]             O_PM_ADDR;
  logic                    I_PM_VALID;
  logic [63:0]             I_PM_DATA;
  logic                    I_MISPREDICT = 1'b0;
  logic [23:0]             I_TARGET_ADDR = 24'h000000;
  logic                    O_WB_VALID;
  cpu_pipe_pkg::halfword_t O_WB_INSTR;
  logic                    O_EXEC_HOLD;
  logic [2:0]              O_OCCUPANCY;
  logic [3:0]              mem_wait = 4'h0;
  logic [23:0]             multi_addr = 24'h000040;
  int failures = 0;
  int comparisons = 0;
  int wb_count, first_lat, since, gaps, holds, req_gap, max_gap, max_occ;
  logic [23:0] exp_pc, exp_fa;

  always #2.5 I_SYS_CLK = ~I_SYS_CLK;

  cpu_pipeline_flow_control #(.QUEUE_DEPTH(8)) cpu_pipeline_flow_control_inst (
    .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .O_PM_REQ(O_PM_REQ), .O_PM_ADDR(O_PM_ADDR),
    .I_PM_VALID(I_PM_VALID), .I_PM_DATA(I_PM_DATA), .I_MISPREDICT(I_MISPREDICT),
    .I_TARGET_ADDR(I_TARGET_ADDR), .O_WB_VALID(O_WB_VALID), .O_WB_INSTR(O_WB_INSTR),
    .O_EXEC_HOLD(O_EXEC_HOLD), .O_OCCUPANCY(O_OCCUPANCY));

  program_memory_model program_memory_model_inst (
    .i_clk(I_SYS_CLK), .i_reset(I_RESET), .i_req(O_PM_REQ), .i_addr(O_PM_ADDR),
    .o_valid(I_PM_VALID), .o_data(I_PM_DATA), .i_wait(mem_wait), .i_multi_addr(multi_addr));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic mark();
    wb_count = 0; first_lat = -1; since = 0; gaps = 0; holds = 0; max_gap = 0; max_occ = 0;
  endtask : mark

  task automatic wait_wb(input int n);
    int t;
    for (t = 0; t < 2000 && wb_count < n; t++) @(negedge I_SYS_CLK);
    if (wb_count < n) begin
      check("write back count", 32'(n), 32'(wb_count));
      tally_and_finish();
    end
  endtask : wait_wb

  // Stream monitor: completions in program order, fetch addresses in double-word steps
  always @(negedge I_SYS_CLK) begin
    if (I_RESET) begin
      exp_pc = 24'h0;
      exp_fa = 24'h0;
    end else begin
      since++;
      req_gap++;
      if (O_OCCUPANCY > max_occ) max_occ = O_OCCUPANCY;
      if (O_EXEC_HOLD === 1'b1) holds++;
      if (O_WB_VALID === 1'b1) begin
        check("wb instr", {16'h0, exp_pc[14:1], (exp_pc == multi_addr) ? 2'h1 : 2'h0}, O_WB_INSTR);
        exp_pc = exp_pc + 24'h2;
        if (first_lat < 0) first_lat = since;
        wb_count++;
      end else if (first_lat >= 0) gaps++;
      if (O_PM_REQ === 1'b1) begin
        check("fetch addr", exp_fa, O_PM_ADDR);
        exp_fa = exp_fa + `PF_ADDR_STEP;
        if (req_gap > max_gap) max_gap = req_gap;
        req_gap = 0;
      end
      if (I_MISPREDICT === 1'b1) begin
        exp_pc = I_TARGET_ADDR & 24'hFFFFFE;
        exp_fa = I_TARGET_ADDR & 24'hFFFFF8;
      end
    end
  end

  task automatic test_sequential();
    check("reset req", 1'b0, O_PM_REQ);
    check("reset addr", 24'h0, O_PM_ADDR);
    check("reset occupancy", 3'h0, O_OCCUPANCY);
    @(posedge I_SYS_CLK) I_RESET <= 1'b0;
    mark();
    req_gap = 0;
    wait_wb(40);
    check("first latency ok", 1'b1, first_lat >= `PIPE_MIN_LATENCY);
    check("peak occupancy", 1'b1, max_occ >= 5 && max_occ <= 6);
    check("bubbles", 32'h1, 32'(gaps));
    check("exec hold cycles", 32'h1, 32'(holds));
    check("fetch stalled", 1'b1, max_gap > 3);
  endtask : test_sequential

  task automatic test_slow_mispredict();
    int t;
    @(posedge I_SYS_CLK) mem_wait <= 4'h4;
    @(negedge I_SYS_CLK);
    for (t = 0; t < 200 && O_PM_REQ !== 1'b1; t++) @(negedge I_SYS_CLK);
    check("fetch request seen", 1'b1, O_PM_REQ);
    @(posedge I_SYS_CLK) begin
      I_MISPREDICT  <= 1'b1;
      I_TARGET_ADDR <= 24'h000106;
    end
    @(posedge I_SYS_CLK) I_MISPREDICT <= 1'b0;
    mark();
    @(negedge I_SYS_CLK);
    check("wb after flush", 1'b0, O_WB_VALID);
    check("restart addr", 24'h000100, O_PM_ADDR);
    wait_wb(20);
    check("restart latency ok", 1'b1, first_lat >= `PIPE_MIN_LATENCY);
  endtask : test_slow_mispredict

  initial begin
    repeat (12) @(posedge I_SYS_CLK);
    @(negedge I_SYS_CLK);
    test_sequential();
    test_slow_mispredict();
    tally_and_finish();
  end
endmodule : test_cpu_pipeline_flow_control

`default_nettype wire
